// [core/nv_supervisor_map.vh]
/*
  Timing constants and state codes for the nonvolatile SRAM supervisor.
  Assumes a 50 MHz mclk and a slow time base of one tick per millisecond.
*/
`ifndef NV_SUPERVISOR_MAP_VH
`define NV_SUPERVISOR_MAP_VH

`define CLK_PERIOD_NS 20
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`TICK_PERIOD_US * 1000) / `CLK_PERIOD_NS)

`define CE_FORCE_NS 1500
`define CE_FORCE_CYCLES (`CE_FORCE_NS / `CLK_PERIOD_NS)

`define RESET_HOLD_MS 200
`define RECOVERY_MS 125
`define WINDOW_MS 1000
`define WARN_INTERVAL_MS 5000
`define NORMAL_INTERVAL_HR 24
`define NORMAL_INTERVAL_MS (`NORMAL_INTERVAL_HR * 3600 * 1000)

`define MS_TO_TICKS(ms) (((ms) * 1000) / `TICK_PERIOD_US)

`define TIMER_W 27
`define CE_CNT_W 7

`define CE_PASS 2'h0
`define CE_HOLD 2'h1
`define CE_BLOCK 2'h2

`define TEST_WAIT 1'h0
`define TEST_LOAD 1'h1

`endif

// [core/slow_tick.v]
/*
  Free-running divider that makes the slow time base for the supervisor.
  Assumes one clock; the tick is a single-cycle pulse every DIV cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module slow_tick
#(
  parameter integer DIV = 50000,
  parameter integer W = 16
)
(
  input wire mclk,
  input wire sys_rst,
  output reg tick
);

  reg [W-1:0] divCount_q;
  wire atEnd;

  assign atEnd = (divCount_q == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1});

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCount_q <= {W{1'b0}};
      tick <= 1'b0;
    end
    else
    begin
      tick <= atEnd;
      if (atEnd)
        divCount_q <= {W{1'b0}};
      else
        divCount_q <= divCount_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// [core/nv_sram_power_supervisor.v]
/*
  Supervisor that makes a static RAM nonvolatile: supply switch control,
  chip-enable write protection, backup cell testing, warning and reset.
  Assumes every analog decision arrives as a comparator bit from a pin and
  that the open-drain outputs are resolved by the wire outside.
*/
// Rules for this block and for the system around it
// RULE_01: Cell feeds RAM below switchover and cell
// RULE_02: Supply failure blocks gated chip enable high
// RULE_03: Access in progress keeps chip enable low
// RULE_04: After release, block until supply returns
// RULE_05: Force chip enable high after 1.5 us
// RULE_06: Tolerance select picks the supply trip level
// RULE_07: Test cell periodically, pause during failure
// RULE_08: Load cell for one second per interval
// RULE_09: Low loaded cell asserts warning output
// RULE_10: Warning shortens interval to detect swaps
// RULE_11: Warning latched until cell replaced
// RULE_12: Retest cell after every supply power-up
// RULE_13: Passing test clears warning, normal interval
// RULE_14: Short swap gap needs another detach
// RULE_15: Cell ignored between scheduled tests
// RULE_16: System powers up periodically, checks data
// RULE_17: Reset asserted while supply below trip
// RULE_18: Reset held 200 ms after power-up
// RULE_19: Storage mode until first supply cycle
// RULE_20: Operator keeps swap gap of 7 s
// RULE_21: Warning within one second of expiry
// RULE_22: Comparator bits in, slow tick timers
`timescale 1ns/1ns
`default_nettype none
`include "nv_supervisor_map.vh"

module nv_sram_power_supervisor
#(
  parameter integer TICK_DIV = `TICK_CYCLES,
  parameter integer RESET_HOLD_TICKS = `MS_TO_TICKS(`RESET_HOLD_MS),
  parameter integer RECOVERY_TICKS = `MS_TO_TICKS(`RECOVERY_MS),
  parameter integer WINDOW_TICKS = `MS_TO_TICKS(`WINDOW_MS),
  parameter integer WARN_TICKS = `MS_TO_TICKS(`WARN_INTERVAL_MS),
  parameter integer NORMAL_TICKS = `MS_TO_TICKS(`NORMAL_INTERVAL_MS)
)
(
  input wire mclk,
  input wire sys_rst,
  input wire hostChipEnableInN,
  input wire toleranceSelect,
  input wire mainAboveTrip30,
  input wire mainAboveTrip27,
  input wire mainAboveSwitchover,
  input wire mainAboveCell,
  input wire cellAboveTrip,
  input wire cellPresent,
  output reg sramChipEnableGatedN,
  output reg cellToSramSupply,
  output reg cellTestLoadOn,
  output reg storageMode,
  output wire cellWarningNOut,
  output reg cellWarningNOe,
  output wire processorResetNOut,
  output reg processorResetNOe
);

  localparam integer NSYNC = 8;
  localparam integer CE_FORCE_I = `CE_FORCE_CYCLES;
  localparam [`CE_CNT_W-1:0] CE_FORCE = CE_FORCE_I[`CE_CNT_W-1:0];
  localparam [`TIMER_W-1:0] ONE = {{(`TIMER_W-1){1'b0}}, 1'b1};

  // Synchroniser stages; stage A is read only by stage B
  reg [NSYNC-1:0] syncA_q;
  reg [NSYNC-1:0] syncB_q;
  wire [NSYNC-1:0] rawIn;
  wire ceInN;
  wire tolSel;
  wire above30;
  wire above27;
  wire aboveSw;
  wire aboveCell;
  wire cellOk;
  wire cellThere;
  wire supplyOk;
  wire tick;

  reg supplyOkPrev_q;
  wire powerUp;

  reg [1:0] ceState_q;
  reg [1:0] ceState_d;
  reg [`CE_CNT_W-1:0] ceCount_q;
  reg [`CE_CNT_W-1:0] ceCount_d;
  reg ceOut_d;

  reg [`TIMER_W-1:0] rstTimer_q;
  reg rstHold_q;

  reg armed_q;

  reg testState_q;
  reg [`TIMER_W-1:0] testTimer_q;
  reg failSeen_q;
  reg absentSeen_q;
  reg removedSeen_q;
  reg firstTest_q;
  reg warning_q;

  function timerDone;
    input [`TIMER_W-1:0] count;
    input integer limit;
    begin
      timerDone = (count >= limit[`TIMER_W-1:0] - ONE);
    end
  endfunction

  assign rawIn = {cellPresent, cellAboveTrip, mainAboveCell, mainAboveSwitchover,
                  mainAboveTrip27, mainAboveTrip30, toleranceSelect, hostChipEnableInN};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1)
    begin : syncBit
      always @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          // Chip enable idles high; everything else idles low
          syncA_q[g] <= (g == 0) ? 1'b1 : 1'b0;
          syncB_q[g] <= (g == 0) ? 1'b1 : 1'b0;
        end
        else
        begin
          syncA_q[g] <= rawIn[g];
          syncB_q[g] <= syncA_q[g];
        end
      end
    end
  endgenerate

  assign ceInN = syncB_q[0];
  assign tolSel = syncB_q[1];
  assign above30 = syncB_q[2];
  assign above27 = syncB_q[3];
  assign aboveSw = syncB_q[4];
  assign aboveCell = syncB_q[5];
  assign cellOk = syncB_q[6];
  assign cellThere = syncB_q[7];

  // Grounded select trips at the 3.0 V level, tied high at the 2.7 V level
  assign supplyOk = tolSel ? above27 : above30; // [RULE_06]

  slow_tick
  #(
    .DIV(TICK_DIV),
    .W(16)
  )
  timeBase
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick)
  ); // [RULE_22]

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      supplyOkPrev_q <= 1'b0;
    else
      supplyOkPrev_q <= supplyOk;
  end

  assign powerUp = supplyOk & ~supplyOkPrev_q;

  // Chip-enable gate: lets a running access go on for up to 1.5 us, then blocks
  always @*
  begin
    ceState_d = ceState_q;
    ceCount_d = ceCount_q;
    ceOut_d = 1'b1;
    case (ceState_q)
      `CE_PASS:
      begin
        ceOut_d = ceInN;
        if (!supplyOk)
        begin
          ceCount_d = {`CE_CNT_W{1'b0}};
          if (!ceInN)
          begin
            ceState_d = `CE_HOLD; // [RULE_03]
            ceOut_d = 1'b0;
          end
          else
          begin
            ceState_d = `CE_BLOCK; // [RULE_02]
            ceOut_d = 1'b1;
          end
        end
      end
      `CE_HOLD:
      begin
        ceOut_d = 1'b0; // [RULE_03]
        ceCount_d = ceCount_q + {{(`CE_CNT_W-1){1'b0}}, 1'b1};
        if (ceInN)
        begin
          ceState_d = `CE_BLOCK; // [RULE_04]
          ceOut_d = 1'b1;
        end
        else if (ceCount_q >= CE_FORCE - {{(`CE_CNT_W-1){1'b0}}, 1'b1})
        begin
          ceState_d = `CE_BLOCK; // [RULE_05]
          ceOut_d = 1'b1;
        end
      end
      `CE_BLOCK:
      begin
        ceOut_d = 1'b1; // [RULE_02]
        if (supplyOk)
        begin
          ceState_d = `CE_PASS; // [RULE_04]
          ceOut_d = ceInN;
        end
      end
      default:
      begin
        ceState_d = `CE_BLOCK;
        ceOut_d = 1'b1;
      end
    endcase
  end

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ceState_q <= `CE_BLOCK;
      ceCount_q <= {`CE_CNT_W{1'b0}};
      sramChipEnableGatedN <= 1'b1;
    end
    else
    begin
      ceState_q <= ceState_d;
      ceCount_q <= ceCount_d;
      sramChipEnableGatedN <= ceOut_d;
    end
  end

  // Processor reset: immediate on failure, stretched on power-up
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rstTimer_q <= {`TIMER_W{1'b0}};
      rstHold_q <= 1'b1;
      processorResetNOe <= 1'b1;
    end
    else
    begin
      if (!supplyOk)
      begin
        rstTimer_q <= {`TIMER_W{1'b0}};
        rstHold_q <= 1'b1; // [RULE_17]
      end
      else if (rstHold_q && tick)
      begin
        if (timerDone(rstTimer_q, RESET_HOLD_TICKS))
          rstHold_q <= 1'b0; // [RULE_18]
        else
          rstTimer_q <= rstTimer_q + ONE;
      end
      processorResetNOe <= !supplyOk | rstHold_q; // [RULE_17]
    end
  end

  assign processorResetNOut = 1'b0;

  // Storage mode: no backup until one full supply cycle is seen
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      armed_q <= 1'b0;
      storageMode <= 1'b1;
      cellToSramSupply <= 1'b0;
    end
    else
    begin
      if (supplyOk)
        armed_q <= 1'b1;
      if (storageMode && armed_q && !aboveSw && !aboveCell)
        storageMode <= 1'b0; // [RULE_19]
      cellToSramSupply <= !storageMode && !aboveSw && !aboveCell; // [RULE_01]
    end
  end

  // Cell test scheduler; the timer only advances with supply good
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      testState_q <= `TEST_WAIT;
      testTimer_q <= {`TIMER_W{1'b0}};
      failSeen_q <= 1'b0;
      absentSeen_q <= 1'b0;
      removedSeen_q <= 1'b0;
      firstTest_q <= 1'b1;
      warning_q <= 1'b0;
      cellTestLoadOn <= 1'b0;
    end
    else if (!supplyOk)
    begin
      // Failure aborts a window; the next power-up retests anyway
      testState_q <= `TEST_WAIT; // [RULE_07]
      testTimer_q <= {`TIMER_W{1'b0}};
      cellTestLoadOn <= 1'b0;
      failSeen_q <= 1'b0;
      absentSeen_q <= 1'b0;
    end
    else if (powerUp)
    begin
      testState_q <= `TEST_WAIT;
      testTimer_q <= {`TIMER_W{1'b0}};
      firstTest_q <= 1'b1; // [RULE_12]
    end
    else
    begin
      case (testState_q)
        `TEST_WAIT:
        begin
          if (tick)
          begin
            if ((firstTest_q && timerDone(testTimer_q, RECOVERY_TICKS)) || // [RULE_07]
                (!firstTest_q && warning_q && timerDone(testTimer_q, WARN_TICKS)) || // [RULE_10]
                (!firstTest_q && !warning_q && timerDone(testTimer_q, NORMAL_TICKS)))
            begin
              testState_q <= `TEST_LOAD;
              testTimer_q <= {`TIMER_W{1'b0}};
              cellTestLoadOn <= 1'b1; // [RULE_08]
              failSeen_q <= 1'b0;
              absentSeen_q <= 1'b0;
            end
            else
              testTimer_q <= testTimer_q + ONE;
          end
        end
        `TEST_LOAD:
        begin
          // Cell comparators only matter inside the window
          if (!cellOk)
            failSeen_q <= 1'b1; // [RULE_09] [RULE_15]
          if (!cellThere)
            absentSeen_q <= 1'b1; // [RULE_14]
          if (tick)
          begin
            if (timerDone(testTimer_q, WINDOW_TICKS))
            begin
              testState_q <= `TEST_WAIT;
              testTimer_q <= {`TIMER_W{1'b0}};
              cellTestLoadOn <= 1'b0;
              firstTest_q <= 1'b0;
              if (failSeen_q || !cellOk)
              begin
                warning_q <= 1'b1; // [RULE_09] [RULE_21]
                if (absentSeen_q || !cellThere)
                  removedSeen_q <= 1'b1; // [RULE_14]
              end
              else if (!warning_q || removedSeen_q || firstTest_q)
              begin
                // Good cell clears only after a swap or on power-up retest
                warning_q <= 1'b0; // [RULE_13] [RULE_11]
                removedSeen_q <= 1'b0;
              end
            end
            else
              testTimer_q <= testTimer_q + ONE;
          end
        end
        default:
        begin
          testState_q <= `TEST_WAIT;
          cellTestLoadOn <= 1'b0;
        end
      endcase
    end
  end

  // Warning survives supply loss; it is driven whenever set, with supply up or down
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cellWarningNOe <= 1'b0;
    else
      cellWarningNOe <= warning_q; // [RULE_11]
  end

  assign cellWarningNOut = 1'b0;

endmodule

`default_nettype wire

// [sim/nv_supervisor_props.sv]
/* Port assertions for the SRAM supervisor.
   Bound to every supervisor instance; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module nv_supervisor_props
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hostChipEnableInN,
  input wire logic toleranceSelect,
  input wire logic mainAboveTrip30,
  input wire logic mainAboveTrip27,
  input wire logic mainAboveSwitchover,
  input wire logic mainAboveCell,
  input wire logic sramChipEnableGatedN,
  input wire logic cellToSramSupply,
  input wire logic cellTestLoadOn,
  input wire logic storageMode,
  input wire logic processorResetNOe
);
  wire logic sok;
  logic [7:0] lowFail_q;
  assign sok = toleranceSelect ? mainAboveTrip27 : mainAboveTrip30;
  // Too long for a repetition, so count it
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      lowFail_q <= 8'h00;
    else if (!sok && !sramChipEnableGatedN)
      lowFail_q <= lowFail_q + 8'h01;
    else
      lowFail_q <= 8'h00;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence failInAccess;
    (!hostChipEnableInN)[*3] ##0 $fell(sok);
  endsequence
  sequence accessHeld;
    (!hostChipEnableInN && !sok)[*8];
  endsequence
  chk_fail_reset: assert property ($fell(sok) |-> ##3 processorResetNOe)
    else $error("reset late on failure");
  chk_ce_block: assert property ((!sok && hostChipEnableInN)[*4] |-> sramChipEnableGatedN)
    else $error("gate open in failure");
  chk_ce_pass: assert property ((sok && $stable(hostChipEnableInN))[*4] |->
    sramChipEnableGatedN == hostChipEnableInN)
    else $error("gate not following host");
  chk_hold_access: assert property (failInAccess ##1 accessHeld |-> !sramChipEnableGatedN)
    else $error("access cut short");
  chk_hold_force: assert property (lowFail_q < 8'h52)
    else $error("gate not forced high");
  chk_release_ce: assert property ($rose(hostChipEnableInN) && !sok |-> ##[1:4] sramChipEnableGatedN)
    else $error("gate not closed on release");
  chk_block_stays: assert property ((!sok)[*4] ##0 sramChipEnableGatedN |=> sramChipEnableGatedN)
    else $error("gate reopened in failure");
  chk_storage_none: assert property (storageMode |-> !cellToSramSupply)
    else $error("backup while in storage");
  chk_backup_off: assert property ((mainAboveSwitchover || mainAboveCell)[*4] |-> !cellToSramSupply)
    else $error("cell feeds RAM with supply up");
  chk_reset_hold: assert property ($rose(sok) |-> processorResetNOe[*8])
    else $error("reset released early");
  chk_load_gated: assert property ((!sok)[*4] |-> !cellTestLoadOn)
    else $error("cell loaded in failure");
endmodule
bind nv_sram_power_supervisor nv_supervisor_props props (.mclk, .sys_rst, .hostChipEnableInN, .toleranceSelect,
  .mainAboveTrip30, .mainAboveTrip27, .mainAboveSwitchover, .mainAboveCell, .sramChipEnableGatedN,
  .cellToSramSupply, .cellTestLoadOn, .storageMode, .processorResetNOe);
`default_nettype wire

// [sim/host_sram_model.sv]
/* Host chip-enable source, backup cell and pin pull-ups.
   Assumes requests change 2 ns after the edge; it acts at 1 ns. */
`timescale 1ns/1ns
`default_nettype none
module host_sram_model
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] accLen,
  input wire logic cellIn,
  input wire logic cellGood,
  input wire logic warnOe,
  input wire logic rstOe,
  input wire logic warnOut,
  input wire logic rstOut,
  output logic ceN,
  output logic cellPresent,
  output logic cellAboveTrip,
  output logic warnN,
  output logic rstN
);
  logic [7:0] left = 8'h00;
  // Long accesses are on purpose, to outlast the force time
  always @(posedge mclk)
  begin
    #1;
    if (go)
      left = accLen;
    else if (left != 8'h00)
      left = left - 8'h01;
  end
  assign ceN = (left == 8'h00);
  // An absent cell reads below trip under load
  assign cellPresent = cellIn;
  assign cellAboveTrip = cellIn & cellGood;
  // Pull-ups win unless the enable is up; the level comes from the data pin
  assign warnN = warnOe ? warnOut : 1'b1;
  assign rstN = rstOe ? rstOut : 1'b1;
endmodule
`default_nettype wire

// [sim/testbench.sv]
/* Self-checking bench for the SRAM supervisor with scaled timers.
   Assumes tick of 4 cycles; host model drives chip enable and cell. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk, sys_rst, tolerance_select, a30, a27, aSw, aCell, cellIn, cellGood, go;
  logic [7:0] accLen;
  wire logic ceN, cellPresent, cellAbove, warnN, rstN, gatedN, toCell, loadOn, storage, warnOe, rstOe;
  wire logic warnOut, rstOut;
  int mismatches = 0;
  int n_checks = 0;
  nv_sram_power_supervisor #(.TICK_DIV(4), .RESET_HOLD_TICKS(3), .RECOVERY_TICKS(2), .WINDOW_TICKS(4),
    .WARN_TICKS(6), .NORMAL_TICKS(10)) dut (.mclk(mclk), .sys_rst(sys_rst), .hostChipEnableInN(ceN),
    .toleranceSelect(tolerance_select), .mainAboveTrip30(a30), .mainAboveTrip27(a27), .mainAboveSwitchover(aSw),
    .mainAboveCell(aCell), .cellAboveTrip(cellAbove), .cellPresent(cellPresent), .sramChipEnableGatedN(gatedN),
    .cellToSramSupply(toCell), .cellTestLoadOn(loadOn), .storageMode(storage), .cellWarningNOut(warnOut),
    .cellWarningNOe(warnOe), .processorResetNOut(rstOut), .processorResetNOe(rstOe));
  host_sram_model host (.mclk(mclk), .go(go), .accLen(accLen), .cellIn(cellIn), .cellGood(cellGood),
    .warnOe(warnOe), .rstOe(rstOe), .warnOut(warnOut), .rstOut(rstOut), .ceN(ceN),
    .cellPresent(cellPresent), .cellAboveTrip(cellAbove),
    .warnN(warnN), .rstN(rstN));
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  function logic sig(input int s);
    case (s)
      0: sig = gatedN;
      1: sig = loadOn;
      2: sig = warnN;
      default: sig = rstN;
    endcase
  endfunction
  // Bounded wait; a hang ends the run at once
  task wt(input int s, input logic v, input int lim);
    int i;
    i = 0;
    while (sig(s) !== v && i < lim)
    begin
      cyc(1);
      i++;
    end
    check(sig(s), v);
    if (sig(s) !== v)
      print_verdict;
  endtask
  task access(input logic [7:0] n);
    accLen = n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task t_storage;
    cyc(6);
    check(storage, 1'b1);
    check(toCell, 1'b0);
    check(rstN, 1'b0);
    check(gatedN, 1'b1);
  endtask
  task t_powerup;
    a30 = 1'b1;
    a27 = 1'b1;
    aSw = 1'b1;
    aCell = 1'b1;
    cyc(10);
    check(rstN, 1'b0);
    wt(3, 1'b1, 30);
    check(storage, 1'b1);
  endtask
  task t_fail_hold;
    access(8'hc8);
    cyc(4);
    check(gatedN, 1'b0);
    a30 = 1'b0;
    aSw = 1'b0;
    aCell = 1'b0;
    cyc(40);
    check(gatedN, 1'b0);
    check(rstN, 1'b0);
    check(toCell, 1'b1);
    check(storage, 1'b0);
    wt(0, 1'b1, 45);
    a30 = 1'b1;
    aSw = 1'b1;
    cyc(4);
    check(gatedN, 1'b0);
    check(toCell, 1'b0);
    aCell = 1'b1;
    wt(0, 1'b1, 200);
  endtask
  task t_fail_release;
    access(8'h14);
    cyc(4);
    a30 = 1'b0;
    wt(0, 1'b1, 25);
    access(8'h14);
    cyc(6);
    check(gatedN, 1'b1);
    check(loadOn, 1'b0);
    check(toCell, 1'b0);
    a30 = 1'b1;
    wt(0, 1'b0, 6);
    wt(0, 1'b1, 20);
  endtask
  task t_tol;
    wt(3, 1'b1, 30);
    tolerance_select = 1'b1;
    a30 = 1'b0;
    cyc(12);
    check(rstN, 1'b1);
    a27 = 1'b0;
    wt(3, 1'b0, 4);
    a27 = 1'b1;
    a30 = 1'b1;
    tolerance_select = 1'b0;
    wt(3, 1'b1, 30);
  endtask
  task t_warn;
    wt(1, 1'b0, 20);
    cellGood = 1'b0;
    wt(1, 1'b1, 60);
    check(warnN, 1'b1);
    cyc(11);
    check(loadOn, 1'b1);
    wt(1, 1'b0, 10);
    wt(2, 1'b0, 8);
    wt(1, 1'b1, 34);
  endtask
  task t_keep;
    a30 = 1'b0;
    cyc(20);
    a30 = 1'b1;
    cellGood = 1'b1;
    cyc(6);
    check(warnN, 1'b0);
    wt(1, 1'b1, 30);
    wt(1, 1'b0, 20);
    wt(2, 1'b1, 8);
    cyc(34);
    check(loadOn, 1'b0);
  endtask
  task t_swap;
    cellGood = 1'b0;
    wt(1, 1'b1, 60);
    wt(1, 1'b0, 20);
    wt(2, 1'b0, 8);
    cellIn = 1'b0;
    wt(1, 1'b1, 34);
    wt(1, 1'b0, 20);
    check(warnN, 1'b0);
    cellIn = 1'b1;
    cellGood = 1'b1;
    wt(1, 1'b1, 34);
    wt(1, 1'b0, 20);
    wt(2, 1'b1, 8);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    sys_rst = 1'b1;
    tolerance_select = 1'b0;
    a30 = 1'b0;
    a27 = 1'b0;
    aSw = 1'b0;
    aCell = 1'b0;
    cellIn = 1'b1;
    cellGood = 1'b1;
    go = 1'b0;
    accLen = 8'h00;
    repeat (16) @(posedge mclk);
    #2;
    sys_rst = 1'b0;
    t_storage;
    t_powerup;
    t_fail_hold;
    t_fail_release;
    t_tol;
    t_warn;
    t_keep;
    t_swap;
    print_verdict;
  end
endmodule
`default_nettype wire
